// >>> shared/gpio_pkg.sv
package gpio_pkg;

  localparam int PINS = 16;
  localparam int CPU_LINES = 5;

  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_DIRECTION = 8'h04;
  localparam logic [7:0] OFS_VALUE = 8'h08;
  localparam logic [7:0] OFS_RISE = 8'h0c;
  localparam logic [7:0] OFS_FALL = 8'h10;
  localparam logic [7:0] OFS_HIGH_MASK = 8'h14;
  localparam logic [7:0] OFS_LOW_MASK = 8'h18;
  localparam logic [7:0] OFS_GLOBAL = 8'h1c;
  localparam logic [7:0] OFS_PT_POLARITY = 8'h20;

  localparam int GC_LOGIC_BIT = 0;
  localparam int GC_DV_BIT = 1;
  localparam int GC_EVENT0_SRC_BIT = 2;
  localparam int GC_PIN0_SRC_BIT = 3;
  localparam int GC_POLARITY_BIT = 4;
  localparam int GC_WIDTH = 5;

  localparam logic [15:0] RST_DIRECTION = 16'h0000;
  localparam logic [15:0] RST_VALUE = 16'h0000;
  localparam logic [15:0] RST_MASK = 16'h0000;
  localparam logic [4:0] RST_GLOBAL = 5'h00;

  localparam logic [1:0] MODE_DELTA_OR = 2'h0;
  localparam logic [1:0] MODE_DELTA_AND = 2'h1;
  localparam logic [1:0] MODE_RESERVED = 2'h2;
  localparam logic [1:0] MODE_VALUE_AND = 2'h3;

  typedef struct packed {
    logic combined_polarity;
    logic pin0_output_source;
    logic event0_source_select;
    logic delta_value_select;
    logic logic_and;
  } global_control_t;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } pin_drive_t;

  typedef struct packed {
    logic [15:0] dma;
    logic [4:0] cpu;
  } event_bus_t;

endpackage : gpio_pkg

// >>> core/gpio_logic_event_combiner.sv
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module gpio_logic_event_combiner (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] config_gpio_strap,
  input wire logic [15:0] pin_in,
  input wire logic [15:0] alt_out,
  input wire logic [15:0] alt_oe,
  output logic [15:0] alt_in,
  output gpio_pkg::pin_drive_t pin_drive,
  output logic combined_logic_event,
  output logic event_line_zero,
  output gpio_pkg::event_bus_t per_pin_event_lines
);
  import gpio_pkg::*;

  logic [15:0] pin_function_enable;
  logic [15:0] direction_bits;
  logic [15:0] pin_value_bits;
  logic [15:0] rise_detect_flags;
  logic [15:0] fall_detect_flags;
  logic [15:0] high_match_mask;
  logic [15:0] low_match_mask;
  logic [15:0] passthrough_polarity;
  global_control_t global_control;

  logic [15:0] pin_meta;
  logic [15:0] pin_level;
  logic [15:0] pin_prev;
  logic [15:0] strap_meta;
  logic [15:0] strap_sync;
  logic [2:0] history_fill;
  // Edges are only believed once the history stage holds a real level, not its reset value.
  // Without this gate a pin that is high at release would set its rise flag by itself.
  wire [15:0] edge_gate = {16{history_fill[2]}};

  // Bus decode. One wait state lets read data and the error flag leave flip-flops.
  wire access = psel & penable;
  wire fire = access & pready;
  wire wr_fire = fire & pwrite;
  wire [7:0] offset = paddr[7:0];
  wire in_range = (paddr[31:8] == 24'h000000) & (paddr[1:0] == 2'h0);
  wire hit_enable = in_range & (offset == OFS_ENABLE);
  wire hit_direction = in_range & (offset == OFS_DIRECTION);
  wire hit_value = in_range & (offset == OFS_VALUE);
  wire hit_rise = in_range & (offset == OFS_RISE);
  wire hit_fall = in_range & (offset == OFS_FALL);
  wire hit_high = in_range & (offset == OFS_HIGH_MASK);
  wire hit_low = in_range & (offset == OFS_LOW_MASK);
  wire hit_global = in_range & (offset == OFS_GLOBAL);
  wire hit_polarity = in_range & (offset == OFS_PT_POLARITY);
  wire mapped = hit_enable | hit_direction | hit_value | hit_rise | hit_fall | hit_high | hit_low
                | hit_global | hit_polarity;

  wire [15:0] wdata16 = pwdata[15:0];

  // Only general-purpose inputs watch the pin; outputs keep their flags.
  wire [15:0] gp_input = pin_function_enable & ~direction_bits;
  wire [15:0] gp_output = pin_function_enable & direction_bits;
  wire [15:0] rise_seen = gp_input & pin_level & ~pin_prev & edge_gate;
  wire [15:0] fall_seen = gp_input & ~pin_level & pin_prev & edge_gate;

  // Value reads back the sampled level on inputs and the stored drive bit on outputs.
  wire [15:0] value_view = (direction_bits & pin_value_bits) | (~direction_bits & pin_level);

  wire [1:0] mode = {global_control.delta_value_select, global_control.logic_and};
  wire any_mask = |(high_match_mask | low_match_mask);

  // Delta sources are the captured flags, value sources the sampled level and its inverse.
  wire [15:0] high_src = global_control.delta_value_select ? pin_level : rise_detect_flags;
  wire [15:0] low_src = global_control.delta_value_select ? ~pin_level : fall_detect_flags;
  wire high_all = &(~high_match_mask | high_src);
  wire low_all = &(~low_match_mask | low_src);
  // A pin masked both ways needs level and inverse at once, so level AND stays false.
  wire and_true = any_mask & high_all & low_all;
  wire or_true = |((high_match_mask & rise_detect_flags) | (low_match_mask & fall_detect_flags));

  logic logic_true;
  always_comb
  begin
    case (mode)
      MODE_DELTA_OR: logic_true = or_true;
      MODE_DELTA_AND: logic_true = and_true;
      MODE_VALUE_AND: logic_true = and_true;
      MODE_RESERVED: logic_true = 1'b0;
      default: logic_true = 1'b0;
    endcase
  end

  // Polarity applies in every mode, the reserved code included.
  wire next_combined = logic_true ^ global_control.combined_polarity;

  // Pass-through lines follow the level or its inverse on enabled inputs only.
  wire [15:0] passthrough_lines = gp_input & (pin_level ^ passthrough_polarity);
  wire next_event_zero = global_control.event0_source_select ? next_combined : passthrough_lines[0];

  logic [15:0] next_lines;
  always_comb
  begin
    next_lines = passthrough_lines;
    next_lines[0] = next_event_zero;
  end

  // Lines 4 to 7 and line zero are the only ones the processor sees.
  wire [4:0] next_cpu = {next_lines[7:4], next_lines[0]};

  // Pin zero may carry the combined event, but only while it is an output.
  logic [15:0] gp_out_value;
  always_comb
  begin
    gp_out_value = pin_value_bits;
    if (gp_output[0] && global_control.pin0_output_source)
    begin
      gp_out_value[0] = next_combined;
    end
  end

  wire [15:0] next_out = (pin_function_enable & gp_out_value) | (~pin_function_enable & alt_out);
  wire [15:0] next_oe = gp_output | (~pin_function_enable & alt_oe);

  // Enabling a pin clears its direction so it never drives before software asks.
  wire [15:0] newly_enabled = wr_fire & hit_enable ? (wdata16 & ~pin_function_enable) : 16'h0000;

  logic [15:0] next_direction;
  always_comb
  begin
    next_direction = direction_bits;
    if (wr_fire && hit_direction)
    begin
      next_direction = wdata16;
    end
    next_direction = next_direction & ~newly_enabled;
  end

  // Write-one-to-clear, with a fresh edge winning over a clear in the same cycle.
  wire [15:0] rise_clear = (wr_fire & hit_rise) ? wdata16 : 16'h0000;
  wire [15:0] fall_clear = (wr_fire & hit_fall) ? wdata16 : 16'h0000;
  wire [15:0] next_rise = (rise_detect_flags & ~rise_clear) | rise_seen;
  wire [15:0] next_fall = (fall_detect_flags & ~fall_clear) | fall_seen;

  // Reserved upper bits read as zero in every register.
  logic [31:0] read_mux;
  always_comb
  begin
    read_mux = 32'h00000000;
    if (hit_enable)
    begin
      read_mux = {16'h0000, pin_function_enable};
    end
    else if (hit_direction)
    begin
      read_mux = {16'h0000, direction_bits};
    end
    else if (hit_value)
    begin
      read_mux = {16'h0000, value_view};
    end
    else if (hit_rise)
    begin
      read_mux = {16'h0000, rise_detect_flags};
    end
    else if (hit_fall)
    begin
      read_mux = {16'h0000, fall_detect_flags};
    end
    else if (hit_high)
    begin
      read_mux = {16'h0000, high_match_mask};
    end
    else if (hit_low)
    begin
      read_mux = {16'h0000, low_match_mask};
    end
    else if (hit_global)
    begin
      read_mux = {27'h0000000, global_control};
    end
    else if (hit_polarity)
    begin
      read_mux = {16'h0000, passthrough_polarity};
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    // The answer comes on the second access cycle. Read data is zero outside it,
    // so a stale word can never be taken by a master that samples late.
    else
    begin
      pready <= access & ~pready;
      prdata <= (access & ~pready & ~pwrite) ? read_mux : 32'h00000000;
      pslverr <= access & ~pready & ~mapped;
    end
  end

  // The strap pins are not on this clock, so they pass two stages before the enable register loads them.
  // These stages run through reset, which is why reset must be held for at least three edges.
  always_ff @(posedge clk)
  begin
    strap_meta <= config_gpio_strap;
    strap_sync <= strap_meta;
  end

  // The level sampled during reset sets each shared pin's role at release.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_function_enable <= strap_sync;
    end
    else if (wr_fire && hit_enable)
    begin
      pin_function_enable <= wdata16;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      direction_bits <= RST_DIRECTION;
      high_match_mask <= RST_MASK;
      low_match_mask <= RST_MASK;
      passthrough_polarity <= RST_MASK;
      global_control <= RST_GLOBAL;
    end
    else
    begin
      direction_bits <= next_direction;
      if (wr_fire && hit_high)
      begin
        high_match_mask <= wdata16;
      end
      if (wr_fire && hit_low)
      begin
        low_match_mask <= wdata16;
      end
      if (wr_fire && hit_polarity)
      begin
        passthrough_polarity <= wdata16;
      end
      if (wr_fire && hit_global)
      begin
        global_control <= pwdata[GC_WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_value_bits <= RST_VALUE;
    end
    else if (wr_fire && hit_value)
    begin
      pin_value_bits <= wdata16;
    end
  end

  // Two stages before any logic looks at a pin; a third gives the previous level.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_meta <= 16'h0000;
      pin_level <= 16'h0000;
      pin_prev <= 16'h0000;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_level <= pin_meta;
      pin_prev <= pin_level;
    end
  end

  // A pin that is already high at release would otherwise read as a rising edge on the third edge.
  // The price is that a real transition before the first edge after reset is not recorded.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      history_fill <= 3'h0;
    end
    else
    begin
      history_fill <= {history_fill[1:0], 1'b1};
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rise_detect_flags <= 16'h0000;
      fall_detect_flags <= 16'h0000;
    end
    else
    begin
      rise_detect_flags <= next_rise;
      fall_detect_flags <= next_fall;
    end
  end

  // Event line zero is also bit zero of the DMA lines.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      combined_logic_event <= 1'b0;
      event_line_zero <= 1'b0;
      per_pin_event_lines <= '0;
      pin_drive <= '0;
      alt_in <= 16'h0000;
    end
    else
    begin
      combined_logic_event <= next_combined;
      event_line_zero <= next_event_zero;
      per_pin_event_lines.dma <= next_lines;
      per_pin_event_lines.cpu <= next_cpu;
      pin_drive.out <= next_out;
      pin_drive.oe <= next_oe;
      alt_in <= ~pin_function_enable & pin_level;
    end
  end

endmodule : gpio_logic_event_combiner

// >>> tb/gpio_checker.sv
`timescale 1ns/1ps
module gpio_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] pin_in,
  input wire logic combined_logic_event,
  input wire logic event_line_zero,
  input wire gpio_pkg::event_bus_t per_pin_event_lines
);
  import gpio_pkg::*;
  logic wr_done;
  assign wr_done = pready && pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  one_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("wait state count");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  idle_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata idle");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper bits read");
  line0_mirror_a: assert property (event_line_zero == per_pin_event_lines.dma[0])
    else $error("line zero mismatch");
  cpu_lines_a: assert property (per_pin_event_lines.cpu == {per_pin_event_lines.dma[7:4], event_line_zero})
    else $error("cpu line set");
  // The event may only move a fixed time after a pin change or a register write.
  event_cause_a: assert property ($changed(combined_logic_event) |-> $past(wr_done) || $past(wr_done, 2) ||
    $past(pin_in, 3) != $past(pin_in, 4) || $past(pin_in, 4) != $past(pin_in, 5))
    else $error("event moved without cause");
endmodule : gpio_checker
bind gpio_logic_event_combiner gpio_checker chk (.*);

// >>> tb/event_sink.sv
`timescale 1ns/1ps
module event_sink (
  input wire logic clk,
  input wire logic reset,
  input wire gpio_pkg::event_bus_t events,
  output logic [7:0] cpu0_hits
);
  import gpio_pkg::*;
  logic last;
  // Only the processor input of line zero is counted, as it alone among the processor inputs can carry the combined event.
  always_ff @(posedge clk)
  begin
    last <= events.cpu[0];
    if (reset)
      cpu0_hits <= 8'h00;
    else if (events.cpu[0] && !last)
      cpu0_hits <= cpu0_hits + 8'h01;
  end
endmodule : event_sink

// >>> tb/tb_gpio_logic_event_combiner.sv
`timescale 1ns/1ps
module tb_gpio_logic_event_combiner;
  import gpio_pkg::*;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, err, comb, ev0;
  logic [31:0] paddr, pwdata, prdata, rv;
  logic [15:0] pin_in, alt_out, alt_oe, alt_in;
  logic [7:0] hits;
  pin_drive_t pd;
  event_bus_t ev;
  int failures, tests_run;
  gpio_logic_event_combiner DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .config_gpio_strap(16'h00f1), .pin_in(pin_in), .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in),
    .pin_drive(pd), .combined_logic_event(comb), .event_line_zero(ev0), .per_pin_event_lines(ev));
  event_sink sink (.clk(clk), .reset(reset), .events(ev), .cpu0_hits(hits));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, {24'h0, a}, d);
  endtask : wr
  // Six edges cover the worst pin to event path of four edges.
  task automatic pins(input logic [15:0] v);
    pin_in <= v;
    repeat (6) @(posedge clk);
  endtask : pins
  task automatic t_regs;
    xfer(1'b0, 32'h0, 32'h0);
    chk(rv, 32'h000000f1);
    wr(OFS_ENABLE, 32'hffffffff);
    xfer(1'b0, 32'h0, 32'h0);
    chk(rv, 32'h0000ffff);
    xfer(1'b0, 32'h24, 32'h0);
    chk({rv[30:0], err}, 32'h1);
    $display("register test done");
  endtask : t_regs
  task automatic t_value;
    pins(16'h0006);
    wr(OFS_HIGH_MASK, 32'h6);
    wr(OFS_GLOBAL, 32'h7);
    pins(16'h0006);
    chk(comb, 32'h1);
    chk(ev0, 32'h1);
    chk(hits, 32'h1);
    pins(16'h0002);
    chk(comb, 32'h0);
    pins(16'h0000);
    pins(16'h0004);
    chk(comb, 32'h0);
    pins(16'h0006);
    wr(OFS_LOW_MASK, 32'h2);
    pins(16'h0006);
    chk(comb, 32'h0);
    wr(OFS_HIGH_MASK, 32'h0);
    wr(OFS_LOW_MASK, 32'h0);
    pins(16'h0006);
    chk(comb, 32'h0);
    wr(OFS_HIGH_MASK, 32'h6);
    wr(OFS_GLOBAL, 32'h17);
    pins(16'h0000);
    chk(comb, 32'h1);
    $display("level mode test done");
  endtask : t_value
  task automatic t_delta;
    wr(OFS_GLOBAL, 32'h5);
    wr(OFS_HIGH_MASK, 32'h2);
    wr(OFS_LOW_MASK, 32'h6);
    pins(16'h0004);
    wr(OFS_RISE, 32'hffff);
    wr(OFS_FALL, 32'hffff);
    pins(16'h0006);
    chk(comb, 32'h0);
    pins(16'h0002);
    chk(comb, 32'h0);
    pins(16'h0000);
    chk({comb, ev0}, 32'h3);
    wr(OFS_GLOBAL, 32'h6);
    pins(16'h0000);
    chk(comb, 32'h0);
    wr(OFS_GLOBAL, 32'h4);
    wr(OFS_RISE, 32'hffff);
    wr(OFS_FALL, 32'hffff);
    pins(16'h0000);
    chk(comb, 32'h0);
    pins(16'h0002);
    chk(comb, 32'h1);
    $display("transition mode test done");
  endtask : t_delta
  task automatic t_pin0;
    wr(OFS_DIRECTION, 32'h1);
    wr(OFS_VALUE, 32'h1);
    wr(OFS_LOW_MASK, 32'h0);
    wr(OFS_GLOBAL, 32'h0b);
    pins(16'h0001);
    chk({pd.out[0], pd.oe[0], ev0}, 32'h2);
    wr(OFS_GLOBAL, 32'h03);
    wr(OFS_VALUE, 32'h0);
    pins(16'h0003);
    chk({pd.out[0], comb}, 32'h1);
    wr(OFS_VALUE, 32'h1);
    wr(OFS_GLOBAL, 32'h0b);
    pins(16'h0003);
    chk({pd.out[0], pd.oe[0], comb}, 32'h7);
    wr(OFS_DIRECTION, 32'h0);
    pins(16'h0003);
    chk({pd.oe[0], ev0}, 32'h1);
    pins(16'h0020);
    chk({ev.dma[5], ev.cpu[2]}, 32'h3);
    wr(OFS_PT_POLARITY, 32'h20);
    pins(16'h0020);
    chk(ev.dma[5], 32'h0);
    $display("pin zero test done");
  endtask : t_pin0
  task automatic t_alt;
    alt_oe <= 16'h0008;
    alt_out <= 16'h0008;
    wr(OFS_DIRECTION, 32'h8);
    wr(OFS_ENABLE, 32'hfff7);
    pins(16'h0008);
    chk({pd.oe[3], pd.out[3], alt_in[3]}, 32'h7);
    wr(OFS_ENABLE, 32'hffff);
    pins(16'h0008);
    chk({pd.oe[3], alt_in[3]}, 32'h0);
    $display("alternate function test done");
  endtask : t_alt
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  initial
  begin
    reset = 1'b1;
    {psel, penable, pwrite, err} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pin_in = 16'h0;
    alt_out = 16'h0;
    alt_oe = 16'h0;
    failures = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs;
    t_value;
    t_delta;
    t_pin0;
    t_alt;
    end_sim;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    end_sim;
  end
endmodule : tb_gpio_logic_event_combiner
